/* File: core/tws_link_engine.sv */
/*
  Link engine: drives SCL and SDA as open-drain pins on the link clock,
  four link clocks per bit. Assumes the link clock runs freely and that
  pin drivers pull low while the enable is high.
*/
`timescale 1ns/10ps
`default_nettype none
module tws_link_engine
  import tws_pkg::*;
(
  // Clock and reset
  input  wire logic link_clk,
  input  wire logic presetn,
  // Register side
  tws_link_if.eng   lk,
  // Pins
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      scl_o,
  output logic      scl_oe,
  output logic      sda_o,
  output logic      sda_oe
);
  import tws_pkg::*;

  logic [1:0]     rst_q;
  logic [2:0]     cmd_q;
  logic [1:0]     en_q;
  logic [1:0]     scl_q;
  logic [1:0]     sda_q;
  tws_eng_state_t state;
  logic [1:0]     ph;
  logic [2:0]     bitn;
  logic [7:0]     txsh;
  logic [7:0]     rxsh;
  logic           master;

  wire rstn_l  = rst_q[1];
  wire cmd_new = cmd_q[2] ^ cmd_q[1];
  wire en_l    = en_q[1];
  wire sda_s   = sda_q[1];

  // Reset release is retimed to the link clock
  always_ff @(posedge link_clk or negedge presetn) begin
    if (!presetn) rst_q <= 2'b00;
    else          rst_q <= {rst_q[0], 1'b1};
  end

  always_ff @(posedge link_clk or negedge rstn_l) begin
    if (!rstn_l) begin
      cmd_q <= 3'b000;
      en_q  <= 2'b00;
      scl_q <= 2'b11;
      sda_q <= 2'b11;
    end else begin
      cmd_q <= {cmd_q[1:0], lk.cmd_tgl};
      en_q  <= {en_q[0], lk.enable};
      scl_q <= {scl_q[0], scl_in};
      sda_q <= {sda_q[0], sda_in};
    end
  end

  always_ff @(posedge link_clk or negedge rstn_l) begin
    if (!rstn_l) begin
      state        <= E_IDLE;
      ph           <= 2'b00;
      bitn         <= 3'b000;
      txsh         <= 8'h00;
      rxsh         <= 8'h00;
      master       <= 1'b0;
      scl_o        <= 1'b0;
      scl_oe       <= 1'b0;
      sda_o        <= 1'b0;
      sda_oe       <= 1'b0;
      lk.done_tgl  <= 1'b0;
      lk.done_code <= ST_IDLE;
      lk.done_stop <= 1'b0;
      lk.rx_data   <= 8'h00;
    end else if (!en_l) begin
      state  <= E_IDLE;
      ph     <= 2'b00;
      master <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      ph <= ph + 2'b01;
      case (state)
        E_IDLE, E_HOLD: begin
          ph <= 2'b00;
          if (cmd_new) begin
            case (lk.cmd_op)
              OP_START: state <= E_START;
              OP_BYTE: begin
                if (master) begin
                  txsh  <= lk.cmd_data;
                  bitn  <= 3'b000;
                  state <= E_BIT;
                end else begin
                  lk.done_tgl  <= ~lk.done_tgl;
                  lk.done_code <= ST_BUS_ERR;
                  lk.done_stop <= 1'b0;
                end
              end
              default: begin
                if (master) begin
                  state <= E_STOP;
                end else begin
                  // Slave recovery: release both lines, no condition on the wire
                  scl_oe       <= 1'b0;
                  sda_oe       <= 1'b0;
                  state        <= E_IDLE;
                  lk.done_tgl  <= ~lk.done_tgl;
                  lk.done_code <= ST_IDLE;
                  lk.done_stop <= 1'b1;
                end
              end
            endcase
          end
        end
        E_START: begin
          case (ph)
            2'b00:   sda_oe <= 1'b0;
            2'b01:   scl_oe <= 1'b0;
            2'b10:   sda_oe <= 1'b1;
            default: begin
              scl_oe       <= 1'b1;
              master       <= 1'b1;
              state        <= E_HOLD;
              lk.done_tgl  <= ~lk.done_tgl;
              lk.done_code <= master ? ST_RESTART : ST_START;
              lk.done_stop <= 1'b0;
            end
          endcase
        end
        E_BIT: begin
          case (ph)
            2'b00:   sda_oe <= ~txsh[7];
            2'b01:   scl_oe <= 1'b0;
            2'b10:   txsh   <= {txsh[6:0], 1'b0};
            default: begin
              // Two sync flops delay the line, so sample only in the last phase
              scl_oe <= 1'b1;
              rxsh   <= {rxsh[6:0], sda_s};
              bitn   <= bitn + 3'b001;
              if (bitn == LAST_BIT) state <= E_ACK;
            end
          endcase
        end
        E_ACK: begin
          case (ph)
            2'b00:   sda_oe <= 1'b0;
            2'b01:   scl_oe <= 1'b0;
            2'b10:   lk.rx_data <= rxsh;
            default: begin
              scl_oe       <= 1'b1;
              state        <= E_HOLD;
              lk.done_code <= sda_s ? ST_DATA_NAK : ST_DATA_ACK;
              lk.done_tgl  <= ~lk.done_tgl;
              lk.done_stop <= 1'b0;
            end
          endcase
        end
        E_STOP: begin
          case (ph)
            2'b00:   sda_oe <= 1'b1;
            2'b01:   scl_oe <= 1'b0;
            2'b10:   sda_oe <= 1'b0;
            default: begin
              master       <= 1'b0;
              state        <= E_IDLE;
              lk.done_tgl  <= ~lk.done_tgl;
              lk.done_code <= ST_IDLE;
              lk.done_stop <= 1'b1;
            end
          endcase
        end
        default: state <= E_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: core/tws_pkg.sv */
/*
  Shared constants and types of the two-wire bus controller: register
  offsets, bit positions, reset values, status codes and engine states.
  Assumes a 32-bit APB slave port and a separate link clock for the engine.
*/
package tws_pkg;
  localparam int unsigned ADDR_W   = 12;
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_DATA = 12'h004;
  localparam logic [11:0] OFS_STAT = 12'h008;

  // Control register bit positions
  localparam int unsigned B_JOB   = 7;
  localparam int unsigned B_START = 5;
  localparam int unsigned B_STOP  = 4;
  localparam int unsigned B_WC    = 3;
  localparam int unsigned B_EN    = 2;
  localparam int unsigned B_IE    = 0;

  // Status register fields
  localparam int unsigned STAT_LSB  = 3;
  localparam int unsigned PRESC_LSB = 0;

  // Reset values
  localparam logic [7:0] DATA_RST  = 8'h00;
  localparam logic [1:0] PRESC_RST = 2'h0;

  // Status codes
  localparam logic [4:0] ST_IDLE     = 5'h1f;
  localparam logic [4:0] ST_START    = 5'h01;
  localparam logic [4:0] ST_RESTART  = 5'h02;
  localparam logic [4:0] ST_DATA_ACK = 5'h05;
  localparam logic [4:0] ST_DATA_NAK = 5'h06;
  localparam logic [4:0] ST_BUS_ERR  = 5'h00;

  // Index of the last bit of a byte on the wire
  localparam logic [2:0] LAST_BIT = 3'h7;

  typedef enum logic [1:0] {
    OP_START = 2'b00,
    OP_BYTE  = 2'b01,
    OP_STOP  = 2'b11
  } tws_op_t;

  typedef enum logic [2:0] {
    E_IDLE  = 3'b000,
    E_START = 3'b001,
    E_BIT   = 3'b011,
    E_ACK   = 3'b010,
    E_STOP  = 3'b110,
    E_HOLD  = 3'b111
  } tws_eng_state_t;
endpackage

/* File: core/tws_link_if.sv */
/*
  Bundle between the register side (pclk) and the link engine (link clock).
  Commands and completions are toggle events; their data are held stable
  by the sender until the matching event has been seen.
*/
`timescale 1ns/10ps
`default_nettype none
interface tws_link_if;
  import tws_pkg::*;
  logic       enable;
  logic       cmd_tgl;
  tws_op_t    cmd_op;
  logic [7:0] cmd_data;
  logic       done_tgl;
  logic [4:0] done_code;
  logic       done_stop;
  logic [7:0] rx_data;

  modport ctl (output enable, cmd_tgl, cmd_op, cmd_data,
               input done_tgl, done_code, done_stop, rx_data);
  modport eng (input enable, cmd_tgl, cmd_op, cmd_data,
               output done_tgl, done_code, done_stop, rx_data);
endinterface
`default_nettype wire

/* File: core/tws_ctrl.sv */
/*
  Two-wire bus controller: APB register file (control, data, status) and
  the pclk half of the link crossing. Assumes an APB master on pclk and a
  free-running link clock for the wire engine.
*/
// Summary of operation
// - Writing one to the stop request while master puts a STOP on the bus.
// - The stop request clears itself once the STOP has been driven.
// - In slave mode a stop request only releases both lines and unaddresses.
// - A data write while no job is pending raises the write collision flag.
// - A data write while a job is pending clears the write collision flag.
// - Enable hands both pins to the controller.
// - Clearing enable switches the controller off and aborts any transfer.
// - Control bit one is reserved and reads zero.
// - With irq enable and global enable set, the request follows job pending.
// - Status bits seven to three give the status code.
// - A status read returns the code together with the two prescaler bits.
// - Status bit two is reserved and reads zero.
`timescale 1ns/10ps
`default_nettype none
module tws_ctrl
  import tws_pkg::*;
(
  // APB
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [tws_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  output logic [31:0]                    prdata,
  output logic                           pready,
  output logic                           pslverr,
  // CPU side
  input  wire logic                      cpu_global_ie,
  output logic                           irq,
  // Link
  input  wire logic                      link_clk,
  input  wire logic                      scl_in,
  input  wire logic                      sda_in,
  output logic                           scl_o,
  output logic                           scl_oe,
  output logic                           sda_o,
  output logic                           sda_oe
);
  import tws_pkg::*;

  tws_link_if lk ();

  logic       job_pending;
  logic       start_bit;
  logic       stop_bit;
  logic       wc_flag;
  logic       en_bit;
  logic       ie_bit;
  logic       busy;
  logic [7:0] data_reg;
  logic [4:0] status_code;
  logic [1:0] presc;
  logic       cmd_tgl;
  tws_op_t    cmd_op;
  logic [2:0] done_q;

  // Decode
  wire acc      = psel & penable & pready;
  wire hit_ctrl = (paddr == OFS_CTRL);
  wire hit_data = (paddr == OFS_DATA);
  wire hit_stat = (paddr == OFS_STAT);
  wire hit_any  = hit_ctrl | hit_data | hit_stat;
  wire wr_ctrl  = acc & pwrite & hit_ctrl;
  wire wr_data  = acc & pwrite & hit_data;
  wire wr_stat  = acc & pwrite & hit_stat;
  wire done_ev  = (done_q[2] ^ done_q[1]) & en_bit;
  wire launch   = wr_ctrl & pwdata[B_JOB] & pwdata[B_EN] & ~busy;
  wire go_start = pwdata[B_START];
  wire go_stop  = ~pwdata[B_START] & pwdata[B_STOP];

  wire [7:0] ctrl_rd = {job_pending, 1'b0, start_bit, stop_bit,
                        wc_flag, en_bit, 1'b0, ie_bit};
  wire [7:0] stat_rd = {status_code, 1'b0, presc};
  wire [7:0] sel_rd  = hit_ctrl ? ctrl_rd :
                       hit_data ? data_reg :
                       hit_stat ? stat_rd : 8'h00;
  wire [31:0] next_prdata = {24'h00_0000, sel_rd};

  assign lk.enable   = en_bit;
  assign lk.cmd_tgl  = cmd_tgl;
  assign lk.cmd_op   = cmd_op;
  assign lk.cmd_data = data_reg;

  // One wait state keeps every bus output registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~hit_any;
      prdata  <= next_prdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) done_q <= 3'b000;
    else          done_q <= {done_q[1:0], lk.done_tgl};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_bit <= 1'b0;
      en_bit    <= 1'b0;
      ie_bit    <= 1'b0;
      presc     <= PRESC_RST;
    end else begin
      if (wr_ctrl) begin
        start_bit <= pwdata[B_START];
        en_bit    <= pwdata[B_EN];
        ie_bit    <= pwdata[B_IE];
      end
      if (wr_stat) presc <= pwdata[PRESC_LSB +: 2];
    end
  end

  // Hardware set wins over software clear on every sticky flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      job_pending <= 1'b0;
      stop_bit    <= 1'b0;
      busy        <= 1'b0;
      status_code <= ST_IDLE;
      cmd_tgl     <= 1'b0;
      cmd_op      <= OP_START;
    end else begin
      if (wr_ctrl && pwdata[B_JOB]) job_pending <= 1'b0;
      if (wr_ctrl && pwdata[B_STOP]) stop_bit <= 1'b1;
      if (wr_ctrl && !pwdata[B_EN]) begin
        busy        <= 1'b0;
        stop_bit    <= 1'b0;
        status_code <= ST_IDLE;
      end
      if (launch) begin
        busy    <= 1'b1;
        cmd_tgl <= ~cmd_tgl;
        cmd_op  <= go_start ? OP_START : go_stop ? OP_STOP : OP_BYTE;
      end
      if (done_ev) begin
        busy        <= 1'b0;
        status_code <= lk.done_code;
        if (lk.done_stop) stop_bit <= 1'b0;
        else              job_pending <= 1'b1;
      end
    end
  end

  // Data only moves while a job is pending or as a byte command completes, so the engine sees it stable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_reg <= DATA_RST;
      wc_flag  <= 1'b0;
    end else begin
      if (wr_data && !job_pending) wc_flag <= 1'b1;
      if (wr_data && job_pending) begin
        wc_flag  <= 1'b0;
        data_reg <= pwdata[7:0];
      end else if (done_ev && cmd_op == OP_BYTE && !lk.done_stop) begin
        data_reg <= lk.rx_data;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) irq <= 1'b0;
    else          irq <= ie_bit & cpu_global_ie & job_pending;
  end

  tws_link_engine u_engine (
    .link_clk (link_clk),
    .presetn  (presetn),
    .lk       (lk.eng),
    .scl_in   (scl_in),
    .sda_in   (sda_in),
    .scl_o    (scl_o),
    .scl_oe   (scl_oe),
    .sda_o    (sda_o),
    .sda_oe   (sda_oe)
  );
endmodule
`default_nettype wire

/* File: testbench/tws_ctrl_asserts.sv */
/*
  Port checker of the two-wire controller, bound into tws_ctrl.
  Assumes one pclk domain at the ports; the link clock is not watched.
*/
`timescale 1ns/10ps
`default_nettype none
module tws_ctrl_asserts
  import tws_pkg::*;
(
  // APB
  input wire logic                        pclk,
  input wire logic                        presetn,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [tws_pkg::ADDR_W-1:0]  paddr,
  input wire logic [31:0]                 pwdata,
  input wire logic [31:0]                 prdata,
  input wire logic                        pready,
  input wire logic                        pslverr,
  // CPU side and pins
  input wire logic                        cpu_global_ie,
  input wire logic                        irq,
  input wire logic                        scl_o,
  input wire logic                        scl_oe,
  input wire logic                        sda_o,
  input wire logic                        sda_oe
);
  import tws_pkg::*;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic mapped;
  wire logic rd_ok;
  assign mapped = paddr == OFS_CTRL || paddr == OFS_DATA || paddr == OFS_STAT;
  assign rd_ok  = pready && !pwrite;

  pready_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("pready missing after wait state");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  unmapped_err_a: assert property (pready && !mapped |-> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (pready && mapped |-> !pslverr)
    else $error("mapped access refused");
  ctrl_reserved_a: assert property (rd_ok && paddr == OFS_CTRL |->
    prdata[31:8] == 24'h00_0000 && !prdata[1] && !prdata[6])
    else $error("control reserved bits set");
  stat_reserved_a: assert property (rd_ok && paddr == OFS_STAT |->
    !prdata[2] && prdata[31:8] == 24'h00_0000)
    else $error("status reserved bit set");
  irq_gate_a: assert property (!cpu_global_ie |=> !irq)
    else $error("irq without global enable");
  open_drain_a: assert property (scl_o == 1'h0 && sda_o == 1'h0)
    else $error("pin driven high");
  abort_rel_a: assert property (pready && pwrite && paddr == OFS_CTRL && !pwdata[B_EN]
    |-> ##[1:12] (!scl_oe && !sda_oe))
    else $error("pins not released on disable");

  cover property (pready && pwrite && mapped);
  cover property (pready && pslverr);
  cover property (irq);
endmodule

bind tws_ctrl tws_ctrl_asserts u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .cpu_global_ie, .irq, .scl_o, .scl_oe, .sda_o,
  .sda_oe);
`default_nettype wire

/* File: testbench/tws_bus_peer.sv */
/*
  Behavioural slave on the wired lines: acknowledges bytes when asked and
  counts STOP conditions. Assumes pull-ups on both lines.
*/
`timescale 1ns/10ps
`default_nettype none
module tws_bus_peer (
  // Bus lines
  input  wire logic scl,
  input  wire logic sda,
  // Control and observation
  input  wire logic ack_en,
  output var logic  pull_sda,
  output var int    n_stop
);
  int nbit;
  initial begin
    pull_sda = 1'h0;
    n_stop   = 0;
    nbit     = 0;
  end
  // START restarts the bit count
  always @(negedge sda) begin
    if (scl) nbit = 0;
  end
  always @(posedge sda) begin
    if (scl) n_stop = n_stop + 1;
  end
  always @(posedge scl) begin
    nbit = nbit + 1;
  end
  // Only change SDA while SCL is low, else a false START or STOP appears
  always @(negedge scl) begin
    pull_sda <= ack_en && nbit == 8;
    if (nbit == 9) nbit = 0;
  end
endmodule
`default_nettype wire

/* File: testbench/tws_ctrl_tb_top.sv */
/*
  Self-checking bench of tws_ctrl: APB register scenarios and bus traffic
  against a slave model. Assumes pull-ups on SCL and SDA.
*/
`timescale 1ns/10ps
`default_nettype none
module tws_ctrl_tb_top;
  import tws_pkg::*;
  logic              pclk = 1'h0, link_clk = 1'h0, presetn = 1'h0;
  logic              psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic              cpu_global_ie = 1'h0, ack_en = 1'h1;
  logic [ADDR_W-1:0] paddr = 12'h000;
  logic [31:0]       pwdata = 32'h0000_0000, prdata, r;
  logic              pready, pslverr, irq, scl_o, scl_oe, sda_o, sda_oe, pull_sda, e;
  wire logic         scl, sda;
  int                n_stop, n_errors = 0, tests_run = 0, cyc = 0;
  assign scl = !scl_oe;
  assign sda = !(sda_oe || pull_sda);

  always #10 pclk = ~pclk;
  initial begin
    #1.7;
    forever #3 link_clk = ~link_clk;
  end

  tws_ctrl dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .cpu_global_ie, .irq, .link_clk, .scl_in(scl), .sda_in(sda),
    .scl_o, .scl_oe, .sda_o, .sda_oe);
  tws_bus_peer peer (.scl, .sda, .ack_en, .pull_sda, .n_stop);

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic print_verdict;
    if (n_errors == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // One APB transfer; waits for pready, bounded
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'h1; penable <= 1'h0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1) chk("apb pready", pready, 1'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'h0; penable <= 1'h0;
  endtask

  task automatic poll(input int b, input logic v);
    for (int k = 0; k < 40; k++) begin
      apb(1'h0, OFS_CTRL, 32'h0000_0000);
      if (r[b] === v) break;
    end
    chk("ctrl poll", r[b], v);
  endtask

  task automatic t_regs;
    apb(1'h0, OFS_CTRL, 32'h0000_0000);
    chk("ctrl reserved", r & 32'h0000_0042, 32'h0000_0000);
    apb(1'h1, OFS_STAT, 32'h0000_00FF);
    apb(1'h0, OFS_STAT, 32'h0000_0000);
    chk("stat idle", r, {24'h00_0000, ST_IDLE, 3'h3});
    apb(1'h1, OFS_STAT, 32'h0000_0000);
    apb(1'h0, 12'h00C, 32'h0000_0000);
    chk("unmapped err", e, 1'h1);
    chk("unmapped data", r, 32'h0000_0000);
  endtask

  task automatic t_wc;
    apb(1'h1, OFS_CTRL, 32'h0000_0004);
    apb(1'h1, OFS_DATA, 32'h0000_005A);
    apb(1'h0, OFS_CTRL, 32'h0000_0000);
    chk("wc set", r[B_WC], 1'h1);
    apb(1'h0, OFS_DATA, 32'h0000_0000);
    chk("data kept", r, DATA_RST);
    chk("bus idle", {scl_oe, sda_oe}, 2'h0);
  endtask

  task automatic t_start;
    cpu_global_ie <= 1'h1;
    apb(1'h1, OFS_CTRL, 32'h0000_00A5);
    poll(B_JOB, 1'h1);
    chk("start kept", r[B_START], 1'h1);
    chk("pins driven", {scl_oe, sda_oe}, 2'h3);
    chk("irq on", irq, 1'h1);
    apb(1'h0, OFS_STAT, 32'h0000_0000);
    chk("start code", r & 32'h0000_00F8, {ST_START, 3'h0});
    cpu_global_ie <= 1'h0;
    repeat (3) @(posedge pclk);
    chk("irq off", irq, 1'h0);
    cpu_global_ie <= 1'h1;
    apb(1'h1, OFS_DATA, 32'h0000_00A5);
    apb(1'h0, OFS_CTRL, 32'h0000_0000);
    chk("wc clear", r[B_WC], 1'h0);
  endtask

  task automatic t_bytes;
    for (int i = 0; i < 2; i++) begin
      ack_en <= (i == 0);
      apb(1'h1, OFS_DATA, 32'h0000_00A5);
      apb(1'h1, OFS_CTRL, 32'h0000_0085);
      poll(B_JOB, 1'h1);
      apb(1'h0, OFS_STAT, 32'h0000_0000);
      chk("byte code", r & 32'h0000_00F8, {i ? ST_DATA_NAK : ST_DATA_ACK, 3'h0});
      apb(1'h0, OFS_DATA, 32'h0000_0000);
      chk("rx byte", r, 32'h0000_00A5);
    end
    // A START while already master is a repeated START
    apb(1'h1, OFS_CTRL, 32'h0000_00A5);
    poll(B_JOB, 1'h1);
    apb(1'h0, OFS_STAT, 32'h0000_0000);
    chk("restart code", r & 32'h0000_00F8, {ST_RESTART, 3'h0});
  endtask

  // First pass is master, second finds the controller already a slave
  task automatic t_stop;
    int s;
    for (int i = 0; i < 2; i++) begin
      s = n_stop;
      apb(1'h1, OFS_CTRL, 32'h0000_0095);
      poll(B_STOP, 1'h0);
      chk("job after stop", r[B_JOB], 1'h0);
      chk("stop count", n_stop - s, (i == 0));
      chk("lines free", {scl, sda}, 2'h3);
    end
    // A byte without mastership is answered with the bus error code
    apb(1'h1, OFS_CTRL, 32'h0000_0084);
    poll(B_JOB, 1'h1);
    apb(1'h0, OFS_STAT, 32'h0000_0000);
    chk("no master code", r & 32'h0000_00F8, {ST_BUS_ERR, 3'h0});
  endtask

  task automatic t_abort;
    apb(1'h1, OFS_CTRL, 32'h0000_00A5);
    poll(B_JOB, 1'h1);
    apb(1'h1, OFS_DATA, 32'h0000_0000);
    apb(1'h1, OFS_CTRL, 32'h0000_0085);
    apb(1'h1, OFS_CTRL, 32'h0000_0000);
    repeat (8) @(posedge pclk);
    chk("released", {scl_oe, sda_oe}, 2'h0);
    apb(1'h0, OFS_CTRL, 32'h0000_0000);
    chk("no done", r[B_JOB], 1'h0);
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      print_verdict();
    end
  end

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    repeat (3) @(posedge pclk);
    t_regs();
    t_wc();
    t_start();
    t_bytes();
    t_stop();
    t_abort();
    print_verdict();
  end
endmodule
`default_nettype wire
